// ==== hw/pcfc_pkg.sv ====
// Purpose: Shared constants for the pixel clock counter and far-end capability registers.
// Assumes: REF_CLK at 200 MHz; the oscillator period is a whole number of REF_CLK periods.
// Notes:   Offsets are register indices on the serial control bus register port.
package pcfc_pkg;

    // Register offsets.
    localparam logic [7:0] PCFC_OFS_FREQ_CNT = 8'h1f;
    localparam logic [7:0] PCFC_OFS_CAP1     = 8'h20;

    // Values after reset.
    localparam logic [7:0] PCFC_RST_FREQ_CNT = 8'h00;
    localparam logic [7:0] PCFC_RST_CAP1     = 8'h00;

    // Capability register field positions.
    localparam int PCFC_BIT_HOLD      = 7;
    localparam int PCFC_BIT_FREQ_TRN  = 5;
    localparam int PCFC_BIT_EQ_TRN    = 4;
    localparam int PCFC_BIT_TWO_LINK  = 3;
    localparam int PCFC_BIT_CHANNEL   = 2;
    localparam int PCFC_BIT_WIDE_VID  = 1;
    localparam int PCFC_BIT_FWD_PIN   = 0;

    // Bits that the control channel may load, and bits that exist at all.
    localparam logic [7:0] PCFC_CAP_LOAD_MASK = 8'h3f & ~8'h40;
    localparam logic [7:0] PCFC_CAP_RW_MASK   = 8'hbf;

    // Timing: oscillator period and the clock period, both in ns.
    localparam int PCFC_OSC_PERIOD_NS = 40;
    localparam int PCFC_CLK_PERIOD_NS = 5;
    localparam int PCFC_OSC_CYCLES    = (PCFC_OSC_PERIOD_NS + PCFC_CLK_PERIOD_NS - 1) / PCFC_CLK_PERIOD_NS;

    // Saturation value of the edge counter.
    localparam logic [7:0] PCFC_CNT_MAX = 8'hff;

    // Measurement states.
    typedef enum logic [0:0]
    {
        PCFC_IDLE    = 1'b0,
        PCFC_MEASURE = 1'b1
    } pcfc_state_e;

endpackage

// ==== hw/pcfc_meas_if.sv ====
// Purpose: Carries the start request and result between the register bank and the frequency meter.
// Assumes: Both ends run on REF_CLK.
// Notes:   start is a one-cycle pulse that carries interval.
`timescale 1ns/10ps
interface pcfc_meas_if;
    logic       start;
    logic [7:0] interval;
    logic [7:0] count;
    logic       busy;

    modport bank  (output start, output interval, input count, input busy);
    modport meter (input start, input interval, output count, output busy);
endinterface

// ==== hw/pcfc_freq_meter.sv ====
// Purpose: Counts rising edges of the sampled pixel clock during a window of oscillator periods.
// Assumes: PIX_CLK is sampled on REF_CLK, so it must run below half of REF_CLK.
// Notes:   The count restarts from zero on every start pulse.
`timescale 1ns/10ps
module pcfc_freq_meter
    import pcfc_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   pix_clk,
    pcfc_meas_if.meter  meas
);
    localparam int WIN_W = 8 + $clog2(PCFC_OSC_CYCLES + 1);

    pcfc_state_e        state_r;
    pcfc_state_e        state_nxt;
    logic [WIN_W-1:0]   win_r;
    logic [WIN_W-1:0]   win_nxt;
    logic [7:0]         cnt_r;
    logic [7:0]         cnt_nxt;
    logic               pix_d_r;
    wire                pix_rise;
    wire                win_last;
    wire [WIN_W-1:0]    win_len;

    // Window length is the written value times the oscillator period in clocks.
    assign win_len  = WIN_W'(meas.interval) * WIN_W'(PCFC_OSC_CYCLES);
    assign pix_rise = pix_clk & ~pix_d_r;
    assign win_last = (win_r == WIN_W'(1));
    assign meas.count = cnt_r;
    assign meas.busy  = (state_r == PCFC_MEASURE);

    // Next state and counters of the measurement.
    always_comb
    begin
        state_nxt = state_r;
        win_nxt   = win_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            PCFC_IDLE:
            begin
                win_nxt = win_r;
            end
            PCFC_MEASURE:
            begin
                if (pix_rise && cnt_r != PCFC_CNT_MAX)
                begin
                    cnt_nxt = cnt_r + 8'h01;
                end
                win_nxt = win_r - WIN_W'(1);
                if (win_last)
                begin
                    state_nxt = PCFC_IDLE;
                end
            end
            default:
            begin
                state_nxt = PCFC_IDLE;
            end
        endcase
        if (meas.start)
        begin
            cnt_nxt   = 8'h00;
            win_nxt   = win_len;
            state_nxt = (win_len == '0) ? PCFC_IDLE : PCFC_MEASURE;
        end
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= PCFC_IDLE;
            win_r   <= '0;
            cnt_r   <= PCFC_RST_FREQ_CNT;
            pix_d_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            win_r   <= win_nxt;
            cnt_r   <= cnt_nxt;
            pix_d_r <= pix_clk;
        end
    end
endmodule

// ==== hw/pcfc_top.sv ====
// Purpose: Pixel clock frequency counter register and first far-end capability register.
// Assumes: The serial control bus decoder presents one register access per strobe on REF_CLK.
// Notes:   Only the two registers at 0x1f and 0x20 hold data; reads of other addresses are answered with zero.
//
// Overview of operation
// - A write to the counter register starts a window in which rising pixel clock edges are counted.
// - The window lasts the written 8-bit value times the 40 ns oscillator period.
// - A read of the counter register returns the edge count of the latest window, not the written value.
// - The edge count stops at 0xff and never wraps.
// - While the hold bit 7 is set the control channel loads nothing and written values stay.
// - With bit 5 set the REQUEST_FREQ_TRAINING output is high to ask for the frequency training pattern.
// - With bit 4 set the REQUEST_EQ_TRAINING output is high to ask for the equalization training pattern.
// - After receiver lock the control channel updates the capability fields unless held.
// - Bit 3 tells whether the far-end receiver can run over two links.
// - Bit 2 gives the channel role, zero for primary channel 0 and one for secondary channel 1.
// - Bit 1 flags 24-bit video with high-definition audio and bit 0 flags forward frame pin support.
`timescale 1ns/10ps
module pcfc_top
    import pcfc_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RESETN,
    input  wire logic       PIX_CLK,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    output logic            REG_RVALID,
    input  wire logic       RX_LOCK,
    input  wire logic       CHAN_CAP_VALID,
    input  wire logic [7:0] CHAN_CAP,
    output logic            REQUEST_FREQ_TRAINING,
    output logic            REQUEST_EQ_TRAINING,
    output logic            TWO_LINK_CAPABLE,
    output logic            SECONDARY_CHANNEL,
    output logic            WIDE_VIDEO_WITH_HD_SOUND,
    output logic            FORWARD_FRAME_PIN_SUPPORT,
    output logic            FREQ_MEASURE_BUSY
);
    pcfc_meas_if meas ();

    logic [7:0] cap_r;
    logic [7:0] cap_nxt;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic       busy_r;
    wire        sel_cnt;
    wire        sel_cap;
    wire        wr_cnt;
    wire        wr_cap;
    wire        chan_load;
    wire [7:0]  rd_mux;

    // Address decode and write strobes.
    assign sel_cnt = (REG_ADDR == PCFC_OFS_FREQ_CNT);
    assign sel_cap = (REG_ADDR == PCFC_OFS_CAP1);
    assign wr_cnt  = REG_WR & sel_cnt;
    assign wr_cap  = REG_WR & sel_cap;

    // The control channel loads only after lock and only while not held.
    assign chan_load = RX_LOCK & CHAN_CAP_VALID & ~cap_r[PCFC_BIT_HOLD];

    // Read data selection; the counter register reads back the edge count.
    assign rd_mux = sel_cnt ? meas.count :
                    sel_cap ? cap_r : 8'h00;

    // Start request to the frequency meter carries the written interval.
    assign meas.start    = wr_cnt;
    assign meas.interval = REG_WDATA;

    // Capability next value; a software write in the same cycle wins over a channel load.
    always_comb
    begin
        cap_nxt = cap_r;
        if (wr_cap)
        begin
            cap_nxt = REG_WDATA & PCFC_CAP_RW_MASK;
        end
        else if (chan_load)
        begin
            cap_nxt = (cap_r & ~PCFC_CAP_LOAD_MASK) | (CHAN_CAP & PCFC_CAP_LOAD_MASK);
        end
    end

    // Register state and read answer.
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cap_r    <= PCFC_RST_CAP1;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            busy_r   <= 1'b0;
        end
        else
        begin
            cap_r    <= cap_nxt;
            rdata_r  <= REG_RD ? rd_mux : rdata_r;
            rvalid_r <= REG_RD;
            busy_r   <= meas.busy;
        end
    end

    // Outputs straight from the capability, read answer and busy flops.
    assign REQUEST_FREQ_TRAINING     = cap_r[PCFC_BIT_FREQ_TRN];
    assign REQUEST_EQ_TRAINING       = cap_r[PCFC_BIT_EQ_TRN];
    assign TWO_LINK_CAPABLE          = cap_r[PCFC_BIT_TWO_LINK];
    assign SECONDARY_CHANNEL         = cap_r[PCFC_BIT_CHANNEL];
    assign WIDE_VIDEO_WITH_HD_SOUND  = cap_r[PCFC_BIT_WIDE_VID];
    assign FORWARD_FRAME_PIN_SUPPORT = cap_r[PCFC_BIT_FWD_PIN];
    assign REG_RDATA                 = rdata_r;
    assign REG_RVALID                = rvalid_r;
    assign FREQ_MEASURE_BUSY         = busy_r;

    // Edge counter measuring the pixel clock.
    pcfc_freq_meter u_meter
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .pix_clk (PIX_CLK),
        .meas    (meas)
    );
endmodule

// ==== bench/pcfc_chk.sv ====
// Purpose: Port checks for pcfc_top.
// Assumes: One clock domain, active-low reset.
// Notes:   The hold bit is tracked from bus writes.
`timescale 1ns/10ps
module pcfc_chk
    import pcfc_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       RESETN,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       REG_RVALID,
    input wire logic       RX_LOCK,
    input wire logic       CHAN_CAP_VALID,
    input wire logic [7:0] CHAN_CAP,
    input wire logic       REQUEST_FREQ_TRAINING,
    input wire logic       REQUEST_EQ_TRAINING,
    input wire logic       TWO_LINK_CAPABLE,
    input wire logic       SECONDARY_CHANNEL,
    input wire logic       WIDE_VIDEO_WITH_HD_SOUND,
    input wire logic       FORWARD_FRAME_PIN_SUPPORT,
    input wire logic       FREQ_MEASURE_BUSY
);
    // Write decodes and the six capability outputs as one field.
    logic       hold_r;
    wire        wf  = REG_WR && REG_ADDR == PCFC_OFS_FREQ_CNT;
    wire        wc  = REG_WR && REG_ADDR == PCFC_OFS_CAP1;
    wire  [5:0] cap = {REQUEST_FREQ_TRAINING, REQUEST_EQ_TRAINING, TWO_LINK_CAPABLE,
                       SECONDARY_CHANNEL, WIDE_VIDEO_WITH_HD_SOUND, FORWARD_FRAME_PIN_SUPPORT};
    // Follows the hold bit as software last wrote it.
    always_ff @(posedge REF_CLK or negedge RESETN)
        if (!RESETN)
            hold_r <= 1'b0;
        else if (wc)
            hold_r <= REG_WDATA[7];
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    property p_rv; REG_RD |=> REG_RVALID; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_rv0; !REG_RD |=> !REG_RVALID; endproperty
    a_rv0: assert property (p_rv0) else $error("answer without read");
    property p_go; wf && REG_WDATA != 8'h00 |-> ##2 FREQ_MEASURE_BUSY; endproperty
    a_go: assert property (p_go) else $error("window did not start");
    property p_len; (wf && REG_WDATA == 8'h01) ##1 (!wf)[*8] |=> FREQ_MEASURE_BUSY ##1 !FREQ_MEASURE_BUSY; endproperty
    a_len: assert property (p_len) else $error("window length wrong");
    property p_n0; (wf && REG_WDATA == 8'h00) ##1 !wf |=> !FREQ_MEASURE_BUSY; endproperty
    a_n0: assert property (p_n0) else $error("zero interval ran");
    property p_cw; wc |=> cap == $past(REG_WDATA[5:0]); endproperty
    a_cw: assert property (p_cw) else $error("capability write lost");
    property p_ld; RX_LOCK && CHAN_CAP_VALID && !hold_r && !wc |=> cap == $past(CHAN_CAP[5:0]); endproperty
    a_ld: assert property (p_ld) else $error("channel load lost");
    property p_hd; (hold_r || !RX_LOCK || !CHAN_CAP_VALID) && !wc |=> $stable(cap); endproperty
    a_hd: assert property (p_hd) else $error("capabilities changed");
    property p_rd; REG_RD && REG_ADDR == PCFC_OFS_CAP1 |=> REG_RDATA == $past({hold_r, 1'b0, cap}); endproperty
    a_rd: assert property (p_rd) else $error("capability read wrong");
endmodule
bind pcfc_top pcfc_chk chk_u (.*);

// ==== bench/pcfc_far_end.sv ====
// Purpose: Far-end model: pixel clock source and control channel.
// Assumes: Pixel clock period is four REF_CLK periods.
// Notes:   An idle capability lane inverts its byte on every clock.
`timescale 1ns/10ps
module pcfc_far_end
(
    input  wire logic       clk,
    input  wire logic       lock,
    input  wire logic       send,
    input  wire logic [7:0] byte_in,
    output logic            pix_clk,
    output logic            rx_lock,
    output logic            cap_valid,
    output logic      [7:0] cap
);
    // Pixel clock offset so its edges never meet the sampling edge.
    // The lane outputs are driven only by the clocked process below, so they have one driver each.
    initial
    begin
        pix_clk   = 1'b0;
        #1;
        forever #10 pix_clk = ~pix_clk;
    end
    // Control channel strobe and byte lane.
    always @(posedge clk)
    begin
        rx_lock   <= lock;
        cap_valid <= send;
        cap       <= send ? byte_in : ~cap;
    end
endmodule

// ==== bench/pcfc_tb_top.sv ====
// Purpose: Self-checking bench for pcfc_top.
// Assumes: REF_CLK 200 MHz, pixel clock 50 MHz.
// Notes:   Reads queue their expected byte; a monitor compares.
`timescale 1ns/10ps
module pcfc_tb_top
    import pcfc_pkg::*;
;
    logic       REF_CLK = 1'b0, RESETN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, lock = 1'b0, send = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, bval = 8'h00, v;
    wire        PIX_CLK, RX_LOCK, CHAN_CAP_VALID, REG_RVALID, REQUEST_FREQ_TRAINING, REQUEST_EQ_TRAINING;
    wire        TWO_LINK_CAPABLE, SECONDARY_CHANNEL, WIDE_VIDEO_WITH_HD_SOUND, FORWARD_FRAME_PIN_SUPPORT;
    wire        FREQ_MEASURE_BUSY;
    wire  [7:0] CHAN_CAP, REG_RDATA;
    int         n_fail = 0, cmp_count = 0;
    logic [7:0] exp_q[$];
    always #2.5 REF_CLK = ~REF_CLK;
    pcfc_top dut_u (.*);
    pcfc_far_end far_u (.clk(REF_CLK), .lock(lock), .send(send), .byte_in(bval), .pix_clk(PIX_CLK),
                        .rx_lock(RX_LOCK), .cap_valid(CHAN_CAP_VALID), .cap(CHAN_CAP));
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Each answered read takes the oldest expected byte.
    always @(posedge REF_CLK)
        if (REG_RVALID === 1'b1)
            chk8("read data", exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx, REG_RDATA);
    // Compares the six capability pins, sampled away from the clock edge.
    task automatic chk_pins(input logic [7:0] e);
        @(negedge REF_CLK);
        chk8("capability pins", e & PCFC_CAP_LOAD_MASK, {2'b00, REQUEST_FREQ_TRAINING, REQUEST_EQ_TRAINING,
             TWO_LINK_CAPABLE, SECONDARY_CHANNEL, WIDE_VIDEO_WITH_HD_SOUND, FORWARD_FRAME_PIN_SUPPORT});
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge REF_CLK);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        exp_q.push_back(e);
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
    endtask
    task automatic push_cap(input logic [7:0] b);
        @(posedge REF_CLK);
        send <= 1'b1;
        bval <= b;
        @(posedge REF_CLK);
        send <= 1'b0;
        repeat (2) @(posedge REF_CLK);
    endtask
    // Runs one window and reads the count; four cycles per pixel period.
    task automatic meas(input logic [7:0] n);
        int i;
        int c;
        c = n * PCFC_OSC_CYCLES / 4;
        wr_reg(PCFC_OFS_FREQ_CNT, n);
        // Busy is looked at on the falling edge, where the flop has settled.
        repeat (3) @(negedge REF_CLK);
        for (i = 0; i < 3000 && FREQ_MEASURE_BUSY !== 1'b0; i++) @(negedge REF_CLK);
        if (i == 3000)
        begin
            n_fail++;
            stop_test();
        end
        rd_reg(PCFC_OFS_FREQ_CNT, c > 255 ? PCFC_CNT_MAX : 8'(c));
    endtask
    initial
    begin
        void'($urandom(32'hdefe));
        repeat (4) @(posedge REF_CLK);
        RESETN <= 1'b1;
        rd_reg(PCFC_OFS_FREQ_CNT, PCFC_RST_FREQ_CNT);
        rd_reg(PCFC_OFS_CAP1, PCFC_RST_CAP1);
        rd_reg(8'h21, 8'h00);
        $display("Test reset values done");
        v = 8'($urandom());
        wr_reg(PCFC_OFS_CAP1, v | 8'h80);
        lock <= 1'b1;
        push_cap(~v);
        rd_reg(PCFC_OFS_CAP1, (v | 8'h80) & PCFC_CAP_RW_MASK);
        chk_pins(v);
        wr_reg(PCFC_OFS_CAP1, v & 8'h7f);
        v = 8'($urandom());
        push_cap(v);
        rd_reg(PCFC_OFS_CAP1, v & PCFC_CAP_LOAD_MASK);
        chk_pins(v);
        lock <= 1'b0;
        push_cap(~v);
        rd_reg(PCFC_OFS_CAP1, v & PCFC_CAP_LOAD_MASK);
        chk_pins(v);
        $display("Test capability hold and load done");
        meas(8'h01);
        meas(8'h64);
        meas(8'hff);
        meas(8'h00);
        meas(8'($urandom_range(120, 1)));
        wr_reg(PCFC_OFS_FREQ_CNT, 8'hff);
        repeat (50) @(posedge REF_CLK);
        meas(8'h01);
        $display("Test frequency counter done");
        repeat (4) @(posedge REF_CLK);
        if (exp_q.size() != 0)
            n_fail++;
        stop_test();
    end
endmodule
